// ===== core/fcs_consts.vh
`ifndef FCS_CONSTS_VH
`define FCS_CONSTS_VH
// register word offsets (one Avalon address each)
`define FCS_REG_CTRL    4'h0
`define FCS_REG_ADDR    4'h1
`define FCS_REG_DATA    4'h2
`define FCS_REG_STATUS  4'h3
`define FCS_REG_RDATA   4'h4
// control field positions
`define FCS_CTRL_GO     0
`define FCS_CTRL_OPLSB  1
`define FCS_CTRL_OPMSB  3
`define FCS_CTRL_HWRST  4
// operation codes
`define FCS_OP_RESET    3'h0
`define FCS_OP_READ     3'h1
`define FCS_OP_PROG     3'h2
`define FCS_OP_CHIP     3'h3
`define FCS_OP_SECT     3'h4
`define FCS_OP_SECTADD  3'h5
`define FCS_OP_SUSP     3'h6
`define FCS_OP_RESUME   3'h7
// command set
`define FCS_UNLOCK1_A   19'h00555
`define FCS_UNLOCK2_A   19'h002aa
`define FCS_UNLOCK1_D   8'haa
`define FCS_UNLOCK2_D   8'h55
`define FCS_CMD_RESET   8'hf0
`define FCS_CMD_PROG    8'ha0
`define FCS_CMD_ESETUP  8'h80
`define FCS_CMD_CHIP    8'h10
`define FCS_CMD_SECT    8'h30
`define FCS_CMD_SUSP    8'hb0
`define FCS_CMD_RESUME  8'h30
// timing
`define FCS_CLK_MHZ     20
`define FCS_SE_WIN_US   50
`define FCS_SE_WIN_CYC  (`FCS_SE_WIN_US * `FCS_CLK_MHZ)
`define FCS_BUS_PH      3
`define FCS_HWRST_CYC   4'ha
`endif

// ===== core/fcs_seq_rom.v
`include "fcs_consts.vh"
// ***************************************************
// command cycle table: address and data per step
// ***************************************************
module fcs_seq_rom
(
	// clock
	input  wire        mclk,
	// lookup
	input  wire [2:0]  op,
	input  wire [2:0]  step,
	input  wire [18:0] userAddr,
	input  wire [7:0]  userData,
	// table entry
	output reg  [18:0] cycAddr,
	output reg  [7:0]  cycData,
	output reg  [2:0]  cycCount
);
	reg [18:0] a;
	reg [7:0]  d;
	reg [2:0]  n;

	always @*
	begin
		a = `FCS_UNLOCK1_A;
		d = `FCS_UNLOCK1_D;
		n = 3'h1;
		case (op)
			`FCS_OP_RESET:
			begin
				d = `FCS_CMD_RESET;
				a = userAddr;
			end
			`FCS_OP_SUSP:
			begin
				d = `FCS_CMD_SUSP;
				a = userAddr;
			end
			`FCS_OP_RESUME:
			begin
				d = `FCS_CMD_RESUME;
				a = userAddr;
			end
			`FCS_OP_SECTADD:
			begin
				d = `FCS_CMD_SECT;
				a = userAddr;
			end
			`FCS_OP_PROG:
			begin
				n = 3'h4;
				case (step)
					3'h0: d = `FCS_UNLOCK1_D;
					3'h1:
					begin
						a = `FCS_UNLOCK2_A;
						d = `FCS_UNLOCK2_D;
					end
					3'h2: d = `FCS_CMD_PROG;
					default:
					begin
						a = userAddr;
						d = userData;
					end
				endcase
			end
			`FCS_OP_CHIP, `FCS_OP_SECT:
			begin
				n = 3'h6;
				case (step)
					3'h1, 3'h4:
					begin
						a = `FCS_UNLOCK2_A;
						d = `FCS_UNLOCK2_D;
					end
					3'h2: d = `FCS_CMD_ESETUP;
					3'h5:
					begin
						if (op == `FCS_OP_CHIP)
							d = `FCS_CMD_CHIP;
						else
						begin
							a = userAddr;
							d = `FCS_CMD_SECT;
						end
					end
					default: d = `FCS_UNLOCK1_D;
				endcase
			end
			default: n = 3'h1;
		endcase
	end

	always @(posedge mclk)
	begin
		cycAddr  <= a;
		cycData  <= d;
		cycCount <= n;
	end
endmodule

// ===== core/fcs_host_ctrl.v
// Functional notes
// - reset aborts identification entry; host must reset to leave it
// - after timing-limit flag set, host writes reset to restore reads
// - byte program is four writes: two unlocks, set-up, address/data
// - hardware reset pin ends operation; host reissues the sequence
// - chip erase is six writes ending with chip-erase command
// - sector erase is six writes ending with sector address and 30
// - extra sector writes must arrive within the 50 us window
// - other command in window aborts; host rewrites whole sequence
//
// Local design decisions: the Avalon-MM interface to the registers and the register offsets.
`include "fcs_consts.vh"
module fcs_host_ctrl
#(
	parameter ADDR_W = 19,
	parameter BUS_PH = `FCS_BUS_PH
)
(
	// clock and reset
	input  wire              mclk,
	input  wire              sys_rst,
	// avalon-mm slave
	input  wire [3:0]        avsAddress,
	input  wire              avsRead,
	input  wire              avsWrite,
	input  wire [31:0]       avsWriteData,
	output reg  [31:0]       avsReadData,
	output wire              avsWaitRequest,
	// flash pins
	output reg  [ADDR_W-1:0] flashAddr,
	input  wire [7:0]        flashDqIn,
	output reg  [7:0]        flashDqOut,
	output reg               flashDqOe,
	output reg               flashCeN,
	output reg               flashWeN,
	output reg               flashOeN,
	output reg               flashRstN,
	input  wire              readyBusyIn
);
	// ***************************************************
	// states
	// ***************************************************
	localparam S_IDLE  = 3'h0;
	localparam S_LOAD  = 3'h1;
	localparam S_SETUP = 3'h2;
	localparam S_STRB  = 3'h3;
	localparam S_HOLD  = 3'h4;
	localparam S_READ  = 3'h5;
	localparam S_RST   = 3'h6;
	localparam [31:0] WIN_LAST = `FCS_SE_WIN_CYC - 1;

	reg [2:0]        state_q;
	reg [2:0]        op_q;
	reg [2:0]        step_q;
	reg [3:0]        ph_q;
	reg [10:0]       win_q;
	reg              winOpen_q;
	reg [ADDR_W-1:0] addr_q;
	reg [7:0]        data_q;
	reg [7:0]        rdata_q;
	reg              ryS1_q;
	reg              ryS2_q;
	reg [7:0]        dqS1_q;
	reg [7:0]        dqS2_q;
	reg              done_q;
	reg              lateAdd_q;
	reg              rdAck_q;
	reg [31:0]       rdMux;

	wire [18:0] cycAddr;
	wire [7:0]  cycData;
	wire [2:0]  cycCount;
	wire        busy = (state_q != S_IDLE);

	fcs_seq_rom u_rom
	(
		.mclk     (mclk),
		.op       (op_q),
		.step     (step_q),
		.userAddr (addr_q[18:0]),
		.userData (data_q),
		.cycAddr  (cycAddr),
		.cycData  (cycData),
		.cycCount (cycCount)
	);

	// ***************************************************
	// avalon slave: one wait on reads, writes ignored while busy
	// ***************************************************
	assign avsWaitRequest = avsRead && !rdAck_q;
	wire ctrlWr = avsWrite && avsAddress == `FCS_REG_CTRL && !busy;

	always @*
	begin
		case (avsAddress)
			`FCS_REG_ADDR:   rdMux = {13'h0, addr_q[18:0]};
			`FCS_REG_DATA:   rdMux = {24'h0, data_q};
			`FCS_REG_STATUS: rdMux = {28'h0, lateAdd_q, winOpen_q,
				ryS2_q, busy};
			`FCS_REG_RDATA:  rdMux = {23'h0, done_q, rdata_q};
			default:         rdMux = 32'h0;
		endcase
	end

	// ***************************************************
	// pin synchronisers and read data register
	// ***************************************************
	always @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ryS1_q <= 1'b1;
			ryS2_q <= 1'b1;
			rdAck_q <= 1'b0;
			avsReadData <= 32'h0;
			dqS1_q <= 8'h0;
			dqS2_q <= 8'h0;
		end
		else
		begin
			ryS1_q <= readyBusyIn;
			ryS2_q <= ryS1_q;
			dqS1_q <= flashDqIn;
			dqS2_q <= dqS1_q;
			rdAck_q <= avsRead && !rdAck_q;
			avsReadData <= rdMux;
		end
	end

	// ***************************************************
	// sequencer
	// ***************************************************
	always @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_q    <= S_IDLE;
			op_q       <= `FCS_OP_READ;
			step_q     <= 3'h0;
			ph_q       <= 4'h0;
			win_q      <= 11'h0;
			winOpen_q  <= 1'b0;
			addr_q     <= {ADDR_W{1'b0}};
			data_q     <= 8'h0;
			rdata_q    <= 8'h0;
			done_q     <= 1'b0;
			lateAdd_q  <= 1'b0;
			flashAddr  <= {ADDR_W{1'b0}};
			flashDqOut <= 8'h0;
			flashDqOe  <= 1'b0;
			flashCeN   <= 1'b1;
			flashWeN   <= 1'b1;
			flashOeN   <= 1'b1;
			flashRstN  <= 1'b1;
		end
		else
		begin
			if (winOpen_q)
			begin
				if (win_q == 11'h0)
					winOpen_q <= 1'b0;
				else
					win_q <= win_q - 11'h1;
			end
			if (avsWrite && avsAddress == `FCS_REG_ADDR && !busy)
				addr_q <= avsWriteData[ADDR_W-1:0];
			if (avsWrite && avsAddress == `FCS_REG_DATA && !busy)
				data_q <= avsWriteData[7:0];
			case (state_q)
				S_IDLE:
				begin
					if (ctrlWr && avsWriteData[`FCS_CTRL_HWRST])
					begin
						flashRstN <= 1'b0;
						winOpen_q <= 1'b0;
						ph_q      <= 4'h0;
						state_q   <= S_RST;
					end
					else if (ctrlWr && avsWriteData[`FCS_CTRL_GO])
					begin
						op_q   <= avsWriteData[`FCS_CTRL_OPMSB:`FCS_CTRL_OPLSB];
						step_q <= 3'h0;
						done_q <= 1'b0;
						if (avsWriteData[`FCS_CTRL_OPMSB:`FCS_CTRL_OPLSB]
							== `FCS_OP_SECTADD)
							lateAdd_q <= !winOpen_q;
						if (avsWriteData[`FCS_CTRL_OPMSB:`FCS_CTRL_OPLSB]
							== `FCS_OP_READ)
							state_q <= S_READ;
						else
							state_q <= S_LOAD;
						ph_q <= 4'h0;
					end
				end
				S_LOAD:
					state_q <= S_SETUP; // table entry registers here
				S_SETUP:
				begin
					flashAddr  <= cycAddr[ADDR_W-1:0];
					flashDqOut <= cycData;
					flashDqOe  <= 1'b1;
					flashCeN   <= 1'b0;
					flashOeN   <= 1'b1;
					ph_q       <= 4'h0;
					state_q    <= S_STRB;
				end
				S_STRB:
				begin
					flashWeN <= 1'b0;
					ph_q     <= ph_q + 4'h1;
					if (ph_q == BUS_PH[3:0])
					begin
						flashWeN <= 1'b1;
						ph_q     <= 4'h0;
						state_q  <= S_HOLD;
					end
				end
				S_HOLD:
				begin
					flashCeN  <= 1'b1;
					flashDqOe <= 1'b0;
					if (step_q + 3'h1 == cycCount)
					begin
						state_q <= S_IDLE;
						done_q  <= 1'b1;
						if (op_q == `FCS_OP_SECT || op_q == `FCS_OP_SECTADD)
						begin
							winOpen_q <= 1'b1;
							win_q <= WIN_LAST[10:0];
						end
						else
							winOpen_q <= 1'b0;
					end
					else
					begin
						step_q  <= step_q + 3'h1;
						state_q <= S_LOAD;
					end
				end
				S_READ:
				begin
					flashAddr <= addr_q;
					flashCeN  <= 1'b0;
					flashOeN  <= 1'b0;
					flashDqOe <= 1'b0;
					ph_q      <= ph_q + 4'h1;
					if (ph_q == BUS_PH[3:0] + 4'h2)
					begin
						rdata_q  <= dqS2_q;
						flashCeN <= 1'b1;
						flashOeN <= 1'b1;
						done_q   <= 1'b1;
						state_q  <= S_IDLE;
					end
				end
				S_RST:
				begin
					ph_q <= ph_q + 4'h1;
					if (ph_q == `FCS_HWRST_CYC)
					begin
						flashRstN <= 1'b1;
						done_q    <= 1'b1;
						state_q   <= S_IDLE;
					end
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end
endmodule

// ===== test/fcs_host_ctrl_chk.sv
`include "fcs_consts.vh"
// ****************
// flash pin checks
// ****************
module fcs_host_ctrl_chk
#(
	parameter ADDR_W = 19,
	parameter BUS_PH = 3
)
(
	// clock and reset
	input wire              mclk,
	input wire              sys_rst,
	// flash pins
	input wire [ADDR_W-1:0] flashAddr,
	input wire [7:0]        flashDqOut,
	input wire              flashDqOe,
	input wire              flashCeN,
	input wire              flashWeN,
	input wire              flashOeN,
	input wire              flashRstN
);
	int weLow_q;
	int oeLow_q;
	int rstLow_q;
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	always @(posedge mclk or posedge sys_rst)
		if (sys_rst)
		begin
			weLow_q <= 0;
			oeLow_q <= 0;
			rstLow_q <= 0;
		end
		else
		begin
			weLow_q <= flashWeN ? 0 : weLow_q + 1;
			oeLow_q <= flashOeN ? 0 : oeLow_q + 1;
			rstLow_q <= flashRstN ? 0 : rstLow_q + 1;
		end
	we_in_ce_a: assert property (!flashWeN |-> !flashCeN)
		else $error("strobe outside select");
	we_setup_a: assert property ($fell(flashWeN) |-> $past(!flashCeN))
		else $error("no select before strobe");
	we_hold_a: assert property (!flashWeN |-> $stable(flashDqOut)
		&& $stable(flashAddr) && flashDqOe) else $error("bus moved");
	we_width_a: assert property ($rose(flashWeN) |-> weLow_q == BUS_PH)
		else $error("strobe width");
	we_release_a: assert property ($rose(flashWeN) |-> ##[1:2]
		flashCeN && !flashDqOe) else $error("bus not released");
	rd_clean_a: assert property (!flashOeN |-> !flashDqOe && flashWeN)
		else $error("read contention");
	rd_width_a: assert property ($rose(flashOeN) |-> oeLow_q == BUS_PH + 2)
		else $error("read width");
	hw_width_a: assert property ($rose(flashRstN)
		|-> rstLow_q == `FCS_HWRST_CYC + 1) else $error("reset width");
	cover property ($rose(flashWeN));
	cover property ($rose(flashOeN));
	cover property ($rose(flashRstN));
endmodule
bind fcs_host_ctrl fcs_host_ctrl_chk #(.ADDR_W(ADDR_W), .BUS_PH(BUS_PH)) u_chk
	(.mclk(mclk), .sys_rst(sys_rst), .flashAddr(flashAddr),
	.flashDqOut(flashDqOut), .flashDqOe(flashDqOe), .flashCeN(flashCeN),
	.flashWeN(flashWeN), .flashOeN(flashOeN), .flashRstN(flashRstN));

// ===== test/fcs_flash_model.sv
module fcs_flash_model
#(
	parameter PROG_NS  = 2000,
	parameter ERASE_NS = 10000
)
(
	// bus
	input  wire [18:0] addr,
	input  wire [7:0]  dqOut,
	input  wire        dqOe,
	input  wire        ceN,
	input  wire        weN,
	input  wire        oeN,
	input  wire        rstN,
	output logic [7:0] dqIn,
	output wire        readyBusy
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0]  mem [int];
	logic [7:0]  last = 8'h00;
	logic [18:0] aLat;
	bit [2:0]    secs [$];
	int          step = 0;
	bit          busy = 0;
	bit          win = 0;
	time         winEnd;
	assign readyBusy = !busy;
	function automatic logic [7:0] rd(int a);
		return mem.exists(a) ? mem[a] : 8'hff;
	endfunction
	always @*
		if (!ceN && !oeN)
			dqIn = busy ? 8'h00 : rd(addr);
		else if (dqOe)
			dqIn = dqOut;
		else
			dqIn = ~last;
	always @(posedge oeN)
		last = rd(addr);
	always @(negedge weN)
		if (!ceN)
			aLat = addr;
	always @(posedge weN)
		if (!ceN)
			cmd(aLat, dqOut);
	always @(negedge rstN)
	begin
		busy = 0;
		win = 0;
		step = 0;
		disable job;
	end
	task automatic cmd(int a, logic [7:0] d);
		int c;
		c = a & 'h7ff;
		if (win && d == 8'h30)
		begin
			secs.push_back(a[18:16]);
			winEnd = $time + 50000;
		end
		else if (win && d != 8'hb0)
		begin
			win = 0;
			busy = 0;
			secs.delete();
		end
		else if (busy || win)
			return;
		else if (d == 8'hf0)
			step = 0;
		else case (step)
			0: step = (c == 'h555 && d == 8'haa) ? 1 : 0;
			1, 4: step = (c == 'h2aa && d == 8'h55) ? step + 1 : 0;
			2: step = c != 'h555 ? 0 : d == 8'ha0 ? 3 : d == 8'h80 ? 6 : 0;
			6: step = (c == 'h555 && d == 8'haa) ? 4 : 0;
			3: begin
				step = 0;
				mem[a] = rd(a) & d;
				busy = 1;
				fork #(PROG_NS) busy = 0; join_none
			end
			5: begin
				step = 0;
				if (c == 'h555 && d == 8'h10)
					secs = '{0, 1, 2, 3, 4, 5, 6, 7};
				else if (d == 8'h30)
					secs.push_back(a[18:16]);
				win = secs.size() != 0;
				busy = win;
				winEnd = $time + (d == 8'h30 ? 50000 : 0);
			end
			default: step = 0;
		endcase
	endtask
	initial forever begin : job
		wait (win);
		while ($time < winEnd) #(winEnd - $time);
		if (win)
		begin
			win = 0;
			#(ERASE_NS);
			foreach (mem[i]) if (i[18:16] inside {secs}) mem[i] = 8'hff;
			secs.delete();
			busy = 0;
		end
	end
endmodule

// ===== test/flash_command_sequencer_tb.sv
`include "fcs_consts.vh"
`define CHK(g, e) begin samplesChecked++; if ((g) !== (e)) \
	begin mismatches++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module flash_command_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk = 1'b0;
	logic        sysRst = 1'b1;
	logic [3:0]  avAddr = 4'h0;
	logic        avRd = 1'b0;
	logic        avWr = 1'b0;
	logic [31:0] avWdata = 32'h0;
	wire  [31:0] avRdata;
	wire         avWait;
	wire  [18:0] fAddr;
	wire  [7:0]  dqIn, dqOut;
	wire         dqOe, ceN, weN, oeN, rstN, rdy;
	int          mismatches = 0;
	int          samplesChecked = 0;
	logic [7:0]  lfsr = 8'h18;
	logic [7:0]  refMem [int];
	logic [31:0] r;
	logic [18:0] a0, a1;
	time         t;
	always #25 mclk = ~mclk;
	fcs_host_ctrl u_fcs_host_ctrl (.mclk(mclk), .sys_rst(sysRst),
		.avsAddress(avAddr), .avsRead(avRd), .avsWrite(avWr),
		.avsWriteData(avWdata), .avsReadData(avRdata),
		.avsWaitRequest(avWait), .flashAddr(fAddr), .flashDqIn(dqIn),
		.flashDqOut(dqOut), .flashDqOe(dqOe), .flashCeN(ceN),
		.flashWeN(weN), .flashOeN(oeN), .flashRstN(rstN),
		.readyBusyIn(rdy));
	fcs_flash_model u_fcs_flash_model (.addr(fAddr), .dqOut(dqOut),
		.dqOe(dqOe), .ceN(ceN), .weN(weN), .oeN(oeN), .rstN(rstN),
		.dqIn(dqIn), .readyBusy(rdy));
	function automatic logic [7:0] nxt();
		lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
		return lfsr;
	endfunction
	task automatic bus(bit wr, logic [3:0] a, logic [31:0] d);
		@(posedge mclk);
		avAddr <= a;
		avWdata <= d;
		avWr <= wr;
		avRd <= !wr;
		do @(posedge mclk); while (avWait !== 1'b0);
		r = avRdata;
		avWr <= 1'b0;
		avRd <= 1'b0;
	endtask
	task automatic doOp(logic [2:0] op, logic [18:0] a, logic [7:0] d,
		bit hw = 0, bit wt = 1);
		bus(1, `FCS_REG_ADDR, {13'h0, a});
		bus(1, `FCS_REG_DATA, {24'h0, d});
		bus(1, `FCS_REG_CTRL, {27'h0, hw, op, 1'b1});
		do bus(0, `FCS_REG_STATUS, 0); while (r[0] !== 1'b0);
		repeat (4) @(posedge mclk);
		if (wt)
			do bus(0, `FCS_REG_STATUS, 0); while (r[1] !== 1'b1);
	endtask
	task automatic prog(logic [18:0] a, logic [7:0] d);
		doOp(`FCS_OP_PROG, a, d);
		refMem[a] = (refMem.exists(a) ? refMem[a] : 8'hff) & d;
	endtask
	task automatic wipe(logic [2:0] s);
		foreach (refMem[i]) if (i[18:16] == s) refMem[i] = 8'hff;
	endtask
	task automatic chkRd(logic [18:0] a);
		doOp(`FCS_OP_READ, a, 8'h0);
		bus(0, `FCS_REG_RDATA, 0);
		`CHK(r[7:0], refMem.exists(a) ? refMem[a] : 8'hff)
	endtask
	task automatic testDone();
		if (mismatches == 0 && samplesChecked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		#3000000;
		mismatches++;
		testDone();
	end
	initial
	begin
		repeat (5) @(posedge mclk);
		sysRst <= 1'b0;
		a0 = 19'({nxt(), nxt(), nxt()});
		a1 = a0 ^ 19'h40001;
		chkRd(a0);
		prog(a0, nxt());
		prog(a1, nxt());
		chkRd(a0);
		chkRd(a1);
		prog(a0, ~refMem[a0] | 8'h0f);
		chkRd(a0);
		doOp(`FCS_OP_RESET, 19'({nxt(), nxt(), nxt()}), 8'hf0);
		chkRd(a1);
		doOp(`FCS_OP_SUSP, a0, 8'h0);
		chkRd(a0);
		doOp(`FCS_OP_RESUME, a1, 8'h0);
		chkRd(a1);
		doOp(`FCS_OP_SECT, a0, 8'h0, 0, 0);
		`CHK(r[2], 1'b1)
		doOp(`FCS_OP_RESET, 19'h0, 8'hf0);
		chkRd(a0);
		doOp(`FCS_OP_SECT, a0, 8'h0, 0, 0);
		doOp(`FCS_OP_SECTADD, a1, 8'h0);
		bus(0, `FCS_REG_STATUS, 0);
		`CHK(r[3:2], 2'b00)
		wipe(a0[18:16]);
		wipe(a1[18:16]);
		chkRd(a0);
		chkRd(a1);
		prog(a1, nxt());
		doOp(`FCS_OP_CHIP, 19'h0, 8'h0, 0, 0);
		t = $time;
		doOp(`FCS_OP_RESET, 19'h0, 8'h0, 1);
		`CHK(($time - t) < 64'h1388, 1'b1)
		chkRd(a1);
		doOp(`FCS_OP_CHIP, 19'h0, 8'h0);
		refMem.delete();
		chkRd(a1);
		testDone();
	end
endmodule
